// ==== flag_alu.sv ====
/*
 flag_alu: combinational result and condition-flag computation.
 assumes: operands and old flags come from registers of the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module flag_alu
   import flag_pkg::*;
(
   // operation
   input  wire op_code_t                 op_i,
   input  wire op_size_t                 size_i,
   // operands
   input  wire logic [flag_pkg::DATA_W-1:0] src_i,
   input  wire logic [flag_pkg::DATA_W-1:0] dst_i,
   input  wire flag_pkg::flags_t         flags_i,
   // answer
   output var  flag_pkg::alu_out_t       out_o
);
   import flag_pkg::*;

   function automatic logic msb(input logic [DATA_W-1:0] v,
                                input op_size_t s);
      unique case (s)
         SZ_BYTE: msb = v[7];
         SZ_WORD: msb = v[15];
         default: msb = v[DATA_W-1];
      endcase
   endfunction

   function automatic logic is_zero(input logic [DATA_W-1:0] v,
                                    input op_size_t s);
      unique case (s)
         SZ_BYTE: is_zero = (v[7:0] == 8'h00);
         SZ_WORD: is_zero = (v[15:0] == 16'h0000);
         default: is_zero = (v == 32'h0000_0000);
      endcase
   endfunction

   logic [DATA_W-1:0] r;
   logic [DATA_W-1:0] bcd;
   logic              sm;
   logic              dm;
   logic              rm;
   logic              dcarry;
   logic [4:0]        lo;
   logic [4:0]        hi;
   flags_t            f;

   always_comb begin
      r      = '0;
      bcd    = '0;
      lo     = '0;
      hi     = '0;
      dcarry = 1'b0;
      f      = flags_i;
      sm     = msb(src_i, size_i);
      dm     = msb(dst_i, size_i);
      unique case (op_i)
         OP_ADD:             r = dst_i + src_i;
         add_with_extend_op: r = dst_i + src_i + {31'h0, flags_i.x};
         OP_SUB, OP_CMP, OP_CAS, dual_compare_and_swap_op:
            r = dst_i - src_i;
         OP_AND:             r = dst_i & src_i;
         OP_OR:              r = dst_i | src_i;
         exclusive_or_op:    r = dst_i ^ src_i;
         OP_MOVE:            r = src_i;
         clear_operand_op:   r = '0;
         sign_extend_op:
            r = (size_i == SZ_WORD) ? {{24{dst_i[7]}}, dst_i[7:0]}
                                    : {{16{dst_i[15]}}, dst_i[15:0]};
         OP_NOT:             r = ~dst_i;
         test_operand_op:    r = dst_i;
         test_and_set_op:    r = dst_i | 32'h0000_0080;
         decimal_add_op: begin
            lo = {1'b0, dst_i[3:0]} + {1'b0, src_i[3:0]}
               + {4'h0, flags_i.x};
            if (lo > 5'h09)
               lo = lo + 5'h06;
            hi = {1'b0, dst_i[7:4]} + {1'b0, src_i[7:4]}
               + {4'h0, lo[4]};
            if (hi > 5'h09) begin
               hi = hi + 5'h06;
               dcarry = 1'b1;
            end
            bcd = {dst_i[31:8], hi[3:0], lo[3:0]};
            r   = bcd;
         end
         default: r = dst_i;
      endcase
      rm = msb(r, size_i);

      // one flag recipe per op class, same for every size and instance
      unique case (op_i)
         OP_ADD, add_with_extend_op: begin
            f.n = rm;
            f.v = (sm & dm & ~rm) | (~sm & ~dm & rm);
            f.c = (sm & dm) | (~rm & dm) | (sm & ~rm);
            f.x = f.c;
            if (op_i == OP_ADD)
               f.z = is_zero(r, size_i);
            else if (!is_zero(r, size_i))
               f.z = 1'b0;
         end
         OP_SUB: begin
            f.n = rm;
            f.z = is_zero(r, size_i);
            f.v = (~sm & dm & ~rm) | (sm & ~dm & rm);
            f.c = (sm & ~dm) | (rm & ~dm) | (sm & rm);
            f.x = f.c;
         end
         OP_CMP, OP_CAS, dual_compare_and_swap_op: begin
            f.n = rm;
            f.z = is_zero(r, size_i);
            f.v = (~sm & dm & ~rm) | (sm & ~dm & rm);
            f.c = (sm & ~dm) | (rm & ~dm) | (sm & rm);
         end
         decimal_add_op: begin
            f.c = dcarry;
            f.x = dcarry;
            if (bcd[7:0] != 8'h00)
               f.z = 1'b0;
         end
         test_and_set_op: begin
            f.n = dm;
            f.z = is_zero(dst_i, size_i);
            f.v = 1'b0;
            f.c = 1'b0;
         end
         default: begin
            f.n = rm;
            f.z = is_zero(r, size_i);
            f.v = 1'b0;
            f.c = 1'b0;
         end
      endcase
      out_o.result = r;
      out_o.flags  = f;
   end

endmodule
`default_nettype wire

// ==== flag_mem.sv ====
/*
 flag_mem: small word memory acting as the destination operand store.
 assumes: single clock, one access per cycle, registered read data.
*/
`timescale 1ns/1ps
`default_nettype none
module flag_mem
   import flag_pkg::*;
#(
   parameter int AW = flag_pkg::MEM_AW
)(
   // clock
   input  wire logic                        clk_i,
   // access
   input  wire flag_pkg::mem_req_t          req_i,
   output logic [flag_pkg::DATA_W-1:0]      rdata_o
);
   import flag_pkg::*;

   logic [DATA_W-1:0] store [0:(1<<AW)-1];

   always_ff @(posedge clk_i) begin
      if (req_i.req && req_i.we)
         store[req_i.addr[AW-1:0]] <= req_i.wdata;
      rdata_o <= store[req_i.addr[AW-1:0]];
   end

endmodule
`default_nettype wire

// ==== flag_pkg.sv ====
/*
 flag_pkg: shared constants and types for the condition-code flag unit.
 assumes: included before every design file of the flag unit.
*/
package flag_pkg;

   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // apb register map
   // ----------------------------------------------------------------
   localparam logic [7:0] FLAGS_OFF   = 8'h00;
   localparam logic [7:0] STATUS_OFF  = 8'h04;
   localparam logic [7:0] OPA_OFF     = 8'h08;
   localparam logic [7:0] OPB_OFF     = 8'h0c;
   localparam logic [7:0] EXT_OFF     = 8'h10;
   localparam logic [7:0] CMD_OFF     = 8'h14;
   localparam logic [7:0] RESULT_OFF  = 8'h18;
   localparam logic [7:0] CMP_OFF     = 8'h1c;
   localparam logic [7:0] UPD_OFF     = 8'h20;
   localparam logic [7:0] MEM_ADR_OFF = 8'h24;
   localparam logic [7:0] MEM_DAT_OFF = 8'h28;

   // flag positions inside flags_t
   localparam int C_BIT = 0;
   localparam int V_BIT = 1;
   localparam int Z_BIT = 2;
   localparam int N_BIT = 3;
   localparam int X_BIT = 4;
   localparam int FLAG_W = 5;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;

   // command register fields
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_OP_W     = 4;
   localparam int CMD_SIZE_LSB = 4;
   localparam int CMD_SIZE_W   = 2;

   // memory model
   localparam int MEM_AW    = 4;
   localparam int TAS_BIT   = 7;

   typedef enum logic [CMD_SIZE_W-1:0] {
      SZ_BYTE = 2'h0,
      SZ_WORD = 2'h1,
      SZ_LONG = 2'h2
   } op_size_t;

   typedef enum logic [CMD_OP_W-1:0] {
      OP_ADD           = 4'h0,
      OP_SUB           = 4'h1,
      OP_CMP           = 4'h2,
      OP_AND           = 4'h3,
      OP_OR            = 4'h4,
      exclusive_or_op  = 4'h5,
      OP_MOVE          = 4'h6,
      clear_operand_op = 4'h7,
      sign_extend_op   = 4'h8,
      OP_NOT           = 4'h9,
      test_operand_op  = 4'ha,
      add_with_extend_op = 4'hb,
      decimal_add_op   = 4'hc,
      test_and_set_op  = 4'hd,
      OP_CAS           = 4'he,
      dual_compare_and_swap_op = 4'hf
   } op_code_t;

   typedef struct packed {
      logic x;
      logic n;
      logic z;
      logic v;
      logic c;
   } flags_t;

   typedef struct packed {
      logic [DATA_W-1:0] result;
      flags_t            flags;
   } alu_out_t;

   typedef struct packed {
      logic              req;
      logic              we;
      logic [MEM_AW-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } mem_req_t;

endpackage

// ==== flag_unit.sv ====
/*
 flag_unit: condition-code flag unit with apb register access.
 holds the flag register, operand registers and an atomic
 read-modify-write sequencer over a private operand memory.
 assumes: apb master on clk_i, synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module flag_unit
   import flag_pkg::*;
(
   // clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // apb slave
   input  wire logic                        psel_i,
   input  wire logic                        penable_i,
   input  wire logic                        pwrite_i,
   input  wire logic [7:0]                  paddr_i,
   input  wire logic [flag_pkg::DATA_W-1:0] pwdata_i,
   output logic [flag_pkg::DATA_W-1:0]      prdata_o,
   output logic                             pready_o,
   output logic                             pslverr_o,
   // flag state for the condition logic, and the sequence bus lock
   output logic [flag_pkg::FLAG_W-1:0]      flags_o,
   output logic                             bus_lock_o
);
   import flag_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ,
      ST_WAIT,
      ST_MODIFY,
      ST_SECOND
   } seq_t;

   typedef struct packed {
      flags_t            flags;
      logic [DATA_W-1:0] opa;
      logic [DATA_W-1:0] opb;
      logic [DATA_W-1:0] opa2;
      logic [DATA_W-1:0] result;
      logic [DATA_W-1:0] cmp;
      logic [DATA_W-1:0] upd;
      logic [DATA_W-1:0] mem_dat;
      logic [MEM_AW-1:0] mem_adr;
      op_code_t          op;
      op_size_t          size;
      logic              second;
      logic              equal1;
      logic [DATA_W-1:0] old1;
      seq_t              seq;
      logic              busy;
      logic              done;
      logic [DATA_W-1:0] rdata;
      logic              ready;
      logic              err;
   } state_t;

   state_t   state_reg;
   state_t   state_next;
   alu_out_t alu;
   mem_req_t mreq;
   logic [DATA_W-1:0] mem_q;
   logic [DATA_W-1:0] alu_src;
   logic [DATA_W-1:0] alu_dst;
   logic              access;
   logic              is_rmw;

   // ----------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------
   always_comb begin
      alu_src = state_reg.opb;
      alu_dst = state_reg.opa;
      if (state_reg.seq == ST_MODIFY) begin
         alu_src = state_reg.cmp;
         alu_dst = mem_q;
      end
      if (state_reg.seq == ST_MODIFY && state_reg.second)
         alu_src = state_reg.opa2;
      if (state_reg.seq == ST_MODIFY && state_reg.op == test_and_set_op)
         alu_src = '0;
   end

   flag_alu u_alu (
      .op_i    (state_reg.op),
      .size_i  (state_reg.size),
      .src_i   (alu_src),
      .dst_i   (alu_dst),
      .flags_i (state_reg.flags),
      .out_o   (alu)
   );

   flag_mem #(
      .AW (MEM_AW)
   ) u_mem (
      .clk_i   (clk_i),
      .req_i   (mreq),
      .rdata_o (mem_q)
   );

   assign access = psel_i && penable_i && !state_reg.ready;
   assign is_rmw = (state_reg.op == test_and_set_op) ||
                   (state_reg.op == OP_CAS) ||
                   (state_reg.op == dual_compare_and_swap_op);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next       = state_reg;
      state_next.ready = 1'b0;
      state_next.err   = 1'b0;
      state_next.done  = 1'b0;
      mreq             = '0;
      mreq.addr        = state_reg.mem_adr;
      mreq.wdata       = state_reg.mem_dat;

      // apb access, one wait state; writes stalled while a sequence runs, reads answered
      if (access && !(pwrite_i && state_reg.busy)) begin
         state_next.ready = 1'b1;
         state_next.rdata = '0;
         if (pwrite_i) begin
            unique case (paddr_i)
               FLAGS_OFF: state_next.flags = pwdata_i[FLAG_W-1:0];
               OPA_OFF:   state_next.opa   = pwdata_i;
               OPB_OFF:   state_next.opb   = pwdata_i;
               EXT_OFF:   state_next.opa2  = pwdata_i;
               CMP_OFF:   state_next.cmp   = pwdata_i;
               UPD_OFF:   state_next.upd   = pwdata_i;
               MEM_ADR_OFF:
                  state_next.mem_adr = pwdata_i[MEM_AW-1:0];
               MEM_DAT_OFF: begin
                  state_next.mem_dat = pwdata_i;
                  mreq.wdata = pwdata_i;
                  mreq.req  = 1'b1;
                  mreq.we   = 1'b1;
               end
               CMD_OFF: begin
                  state_next.op   = op_code_t'(
                     pwdata_i[CMD_OP_LSB +: CMD_OP_W]);
                  state_next.size = op_size_t'(
                     pwdata_i[CMD_SIZE_LSB +: CMD_SIZE_W]);
                  state_next.busy = 1'b1;
                  state_next.second = 1'b0;
               end
               default: state_next.err = 1'b1;
            endcase
         end else begin
            unique case (paddr_i)
               FLAGS_OFF:  state_next.rdata = {27'h0, state_reg.flags};
               STATUS_OFF: state_next.rdata = {30'h0, state_reg.equal1,
                                               state_reg.busy};
               OPA_OFF:    state_next.rdata = state_reg.opa;
               OPB_OFF:    state_next.rdata = state_reg.opb;
               EXT_OFF:    state_next.rdata = state_reg.opa2;
               RESULT_OFF: state_next.rdata = state_reg.result;
               CMP_OFF:    state_next.rdata = state_reg.cmp;
               UPD_OFF:    state_next.rdata = state_reg.upd;
               MEM_ADR_OFF:
                  state_next.rdata = {28'h0, state_reg.mem_adr};
               MEM_DAT_OFF: state_next.rdata = mem_q;
               default:    state_next.err = 1'b1;
            endcase
         end
      end

      // ----------------------------------------------------------------
      // operation sequencer
      // ----------------------------------------------------------------
      unique case (state_reg.seq)
         ST_IDLE: begin
            if (state_reg.busy) begin
               if (is_rmw) begin
                  state_next.seq = ST_READ;
               end else begin
                  state_next.flags  = alu.flags;
                  state_next.result = alu.result;
                  state_next.opa    = alu.result;
                  if (state_reg.op == OP_CMP)
                     state_next.opa = state_reg.opa;
                  state_next.busy = 1'b0;
               end
            end
         end
         ST_READ: begin
            state_next.seq = ST_WAIT;
         end
         ST_WAIT: begin
            state_next.seq = ST_MODIFY;
         end
         ST_MODIFY: begin
            state_next.flags  = alu.flags;
            state_next.result = alu.result;
            mreq.req = 1'b1;
            if (state_reg.op == test_and_set_op) begin
               mreq.we    = 1'b1;
               mreq.wdata = {mem_q[DATA_W-1:8], alu.result[7:0]};
               state_next.busy = 1'b0;
               state_next.seq  = ST_IDLE;
            end else if (state_reg.op == OP_CAS || state_reg.second) begin
               if (alu.flags.z && (state_reg.op == OP_CAS ||
                                   state_reg.equal1)) begin
                  mreq.we    = 1'b1;
                  mreq.wdata = state_reg.upd;
                  if (state_reg.second) begin
                     mreq.addr  = state_reg.mem_adr;
                     mreq.wdata = state_reg.opb;
                     state_next.mem_dat = state_reg.opb;
                  end
               end else begin
                  // dual swap: compare register gets the first old word
                  state_next.cmp = state_reg.second ? state_reg.old1
                                                    : mem_q;
               end
               if (state_reg.second && state_reg.equal1 && alu.flags.z)
                  state_next.seq = ST_SECOND;
               else begin
                  state_next.seq  = ST_IDLE;
                  state_next.busy = 1'b0;
               end
            end else begin
               state_next.equal1  = alu.flags.z;
               state_next.old1    = mem_q;
               state_next.second  = 1'b1;
               state_next.mem_adr = state_reg.mem_adr + 4'h1;
               mreq.addr = state_reg.mem_adr + 4'h1;
               state_next.seq = ST_WAIT;
            end
         end
         ST_SECOND: begin
            // dual swap: both matched, store first update word too
            mreq.req   = 1'b1;
            mreq.we    = 1'b1;
            mreq.addr  = state_reg.mem_adr - 4'h1;
            mreq.wdata = state_reg.upd;
            state_next.seq  = ST_IDLE;
            state_next.busy = 1'b0;
         end
         default: state_next.seq = ST_IDLE;
      endcase
      if (state_reg.seq == ST_MODIFY && state_reg.second &&
          !(state_reg.equal1 && alu.flags.z))
         state_next.opa2 = mem_q;
      if (state_reg.seq == ST_READ)
         mreq.addr = state_reg.mem_adr;
      if (state_reg.seq == ST_IDLE && state_reg.busy && is_rmw)
         state_next.equal1 = 1'b0;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg       <= '0;
         state_reg.flags <= FLAGS_RESET;
         state_reg.seq   <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata_o   = state_reg.rdata;
   assign pready_o   = state_reg.ready;
   assign pslverr_o  = state_reg.err;
   assign flags_o    = state_reg.flags;
   assign bus_lock_o = state_reg.seq != ST_IDLE;

endmodule
`default_nettype wire

// ==== flag_unit_properties.sv ====
/*
 flag_unit_chk: bus timing and flag update properties of flag_unit.
 assumes: bound to flag_unit, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module flag_unit_chk
   import flag_pkg::*;
(
   // watched ports
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  psel_i,
   input wire logic                  penable_i,
   input wire logic                  pwrite_i,
   input wire logic [31:0]           prdata_o,
   input wire logic                  pready_o,
   input wire logic                  pslverr_o,
   input wire logic [FLAG_W-1:0]     flags_o,
   input wire logic                  bus_lock_o
);
   int unsigned since_wr;
   // cycles since the last write request
   always_ff @(posedge clk_i) begin
      if (rst_i || (psel_i && pwrite_i))
         since_wr <= 0;
      else if (since_wr < 15)
         since_wr <= since_wr + 1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_access;
      psel_i && penable_i && !pready_o && !pwrite_i;
   endsequence
   sequence s_lock_start;
      $rose(bus_lock_o);
   endsequence
   property p_ready_cause;
      pready_o |-> $past(psel_i) && $past(penable_i);
   endproperty
   property p_ready_pulse;
      pready_o |=> !pready_o;
   endproperty
   property p_read_answer;
      s_access |-> ##1 pready_o;
   endproperty
   property p_err_read;
      pslverr_o |-> pready_o && (pwrite_i || prdata_o == 32'h0);
   endproperty
   property p_lock_bound;
      s_lock_start |-> ##[1:12] !bus_lock_o;
   endproperty
   property p_lock_cause;
      s_lock_start |-> since_wr < 6;
   endproperty
   property p_flags_quiet;
      $changed(flags_o) |-> since_wr < 6 || bus_lock_o || $past(bus_lock_o);
   endproperty
   property p_reset_clear;
      $fell(rst_i) |-> flags_o == FLAGS_RESET && !bus_lock_o;
   endproperty
   a_ready_cause: assert property (p_ready_cause)
      else $error("ready without access phase");
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready longer than one cycle");
   a_read_answer: assert property (p_read_answer)
      else $error("read not answered after one wait state");
   a_err_read: assert property (p_err_read)
      else $error("bad error response");
   a_lock_bound: assert property (p_lock_bound)
      else $error("locked sequence too long");
   a_lock_cause: assert property (p_lock_cause)
      else $error("lock without command");
   a_flags_quiet: assert property (p_flags_quiet)
      else $error("flags changed without operation");
   a_reset_clear: assert property (p_reset_clear)
      else $error("flags not cleared by reset");
endmodule
bind flag_unit flag_unit_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .flags_o(flags_o), .bus_lock_o(bus_lock_o));
`default_nettype wire

// ==== tb.sv ====
/*
 tb: self-checking bench of flag_unit over apb.
 assumes: flag_pkg compiled first, registers answer with pready_o.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import flag_pkg::*;
   logic        clk_i, rst_i, psel_i, penable_i, pwrite_i;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic        pready_o, pslverr_o, bus_lock_o, err;
   logic [4:0]  flags_o;
   int          fails = 0, checks_done = 0, lock_cnt = 0, n;
   op_code_t    lops[9] = '{OP_AND, OP_OR, exclusive_or_op, OP_MOVE,
      clear_operand_op, sign_extend_op, OP_NOT, test_operand_op, OP_CMP};
   op_size_t    lsz[9] = '{SZ_LONG, SZ_BYTE, SZ_WORD, SZ_LONG, SZ_BYTE,
      SZ_LONG, SZ_LONG, SZ_BYTE, SZ_LONG};
   logic [31:0] ldst[9] = '{32'hf0f00000, 32'h100, 32'h8000, 32'h5,
      32'h80, 32'h8000, 32'hffffffff, 32'h7f, 32'h1};
   logic [31:0] lsrc[9] = '{32'hff000000, 0, 0, 0, 0, 0, 0, 0, 32'h2};
   logic [4:0]  lexp[9] = '{5'h18, 5'h14, 5'h18, 5'h14, 5'h14, 5'h18,
      5'h14, 5'h10, 5'h19};
   flag_unit dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .flags_o(flags_o), .bus_lock_o(bus_lock_o));
   initial begin
      clk_i = 0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (bus_lock_o === 1'b1) lock_cnt <= lock_cnt + 1;
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task final_report;
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp,
              input string what);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1;
      // waits for the answer; only the watchdog ends a hang
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task run(input op_code_t op, input op_size_t sz,
            input logic [31:0] dst, input logic [31:0] src);
      apb(1, OPA_OFF, dst);
      apb(1, OPB_OFF, src);
      apb(1, CMD_OFF, {26'h0, sz, op});
      do apb(0, STATUS_OFF, 0); while (rd[0] !== 1'b0);
   endtask
   task flags_is(input logic [4:0] exp, input string what);
      apb(0, FLAGS_OFF, 0);
      check(rd, {27'h0, exp}, what);
      check({27'h0, flags_o}, {27'h0, exp}, what);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset;
      flags_is(5'h00, "reset flags");
      apb(1, FLAGS_OFF, 32'h1f);
      flags_is(5'h1f, "flags rw");
      apb(0, 8'h3c, 0);
      check({31'h0, err}, 1, "unmapped err");
      check(rd, 0, "unmapped data");
   endtask
   task t_arith;
      run(OP_ADD, SZ_LONG, 32'h7fffffff, 1);
      flags_is(5'h0a, "add overflow");
      apb(0, OPA_OFF, 0);
      check(rd, 32'h80000000, "add dest");
      run(OP_ADD, SZ_BYTE, 32'hff, 1);
      flags_is(5'h15, "add carry");
      run(OP_SUB, SZ_WORD, 0, 1);
      flags_is(5'h19, "sub borrow");
      run(OP_SUB, SZ_BYTE, 32'h80, 1);
      flags_is(5'h02, "sub overflow");
      apb(0, RESULT_OFF, 0);
      check(rd, 32'h7f, "sub result");
   endtask
   task t_logic;
      for (int i = 0; i < 9; i++) begin
         apb(1, FLAGS_OFF, 32'h1f);
         run(lops[i], lsz[i], ldst[i], lsrc[i]);
         flags_is(lexp[i], "logic flags");
      end
   endtask
   task t_extend;
      apb(1, FLAGS_OFF, 32'h14);
      run(add_with_extend_op, SZ_LONG, 0, 0);
      flags_is(5'h00, "add_with_extend_op nonzero");
      apb(1, FLAGS_OFF, 32'h04);
      run(add_with_extend_op, SZ_LONG, 0, 0);
      flags_is(5'h04, "add_with_extend_op zero kept");
      apb(1, FLAGS_OFF, 32'h04);
      run(decimal_add_op, SZ_BYTE, 5, 4);
      apb(0, FLAGS_OFF, 0);
      check(rd & 32'h15, 0, "bcd flags");
      apb(0, RESULT_OFF, 0);
      check(rd & 32'hff, 32'h09, "bcd result");
      apb(1, FLAGS_OFF, 32'h04);
      run(decimal_add_op, SZ_BYTE, 32'h99, 1);
      apb(0, FLAGS_OFF, 0);
      check(rd & 32'h15, 32'h15, "bcd carry");
   endtask
   task t_tas;
      apb(1, MEM_ADR_OFF, 3);
      apb(1, MEM_DAT_OFF, 32'h40);
      apb(1, FLAGS_OFF, 32'h10);
      n = lock_cnt;
      run(test_and_set_op, SZ_BYTE, 0, 0);
      flags_is(5'h10, "tas flags");
      check({31'h0, lock_cnt > n}, 1, "tas locked");
      apb(0, MEM_DAT_OFF, 0);
      check(rd, 32'hc0, "tas write");
      apb(1, MEM_DAT_OFF, 0);
      run(test_and_set_op, SZ_BYTE, 0, 0);
      flags_is(5'h14, "tas zero");
      apb(0, MEM_DAT_OFF, 0);
      check(rd, 32'h80, "tas set");
   endtask
   task t_dual;
      apb(1, MEM_ADR_OFF, 9);
      apb(1, MEM_DAT_OFF, 32'h22);
      apb(1, MEM_ADR_OFF, 8);
      apb(1, MEM_DAT_OFF, 32'h11);
      apb(1, CMP_OFF, 32'h11);
      apb(1, EXT_OFF, 32'h22);
      apb(1, UPD_OFF, 32'h33);
      apb(1, FLAGS_OFF, 0);
      n = lock_cnt;
      run(dual_compare_and_swap_op, SZ_LONG, 0, 32'h44);
      flags_is(5'h04, "dual equal");
      check({31'h0, lock_cnt > n}, 1, "dual locked");
      apb(0, MEM_DAT_OFF, 0);
      check(rd, 32'h44, "dual second");
      apb(1, MEM_ADR_OFF, 8);
      apb(0, MEM_DAT_OFF, 0);
      check(rd, 32'h33, "dual first");
      apb(1, CMP_OFF, 32'h33);
      apb(1, EXT_OFF, 32'h55);
      run(dual_compare_and_swap_op, SZ_LONG, 0, 32'h66);
      flags_is(5'h09, "dual differ");
      apb(0, EXT_OFF, 0);
      check(rd, 32'h44, "dual load");
      apb(0, CMP_OFF, 0);
      check(rd, 32'h33, "dual cmp");
      apb(0, MEM_DAT_OFF, 0);
      check(rd, 32'h44, "dual kept");
   endtask
   task t_cas;
      apb(1, MEM_ADR_OFF, 5);
      apb(1, MEM_DAT_OFF, 32'h10);
      apb(1, CMP_OFF, 32'h10);
      apb(1, UPD_OFF, 32'h22);
      apb(1, FLAGS_OFF, 0);
      n = lock_cnt;
      run(OP_CAS, SZ_LONG, 0, 0);
      flags_is(5'h04, "cas equal");
      check({31'h0, lock_cnt > n}, 1, "cas locked");
      apb(0, MEM_DAT_OFF, 0);
      check(rd, 32'h22, "cas update");
      apb(1, CMP_OFF, 32'h30);
      run(OP_CAS, SZ_LONG, 0, 0);
      flags_is(5'h09, "cas differ");
      apb(0, CMP_OFF, 0);
      check(rd, 32'h22, "cas load");
   endtask
   initial begin
      rst_i = 1;
      psel_i = 0;
      penable_i = 0;
      pwrite_i = 0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      t_reset();
      t_arith();
      t_logic();
      t_extend();
      t_tas();
      t_cas();
      t_dual();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      final_report();
   end
endmodule
`default_nettype wire
